// File: include/iclm_pkg.sv
// package for the input clock loss monitor: register map, fields, resets
package iclm_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_STICKY = 4'h8;
    localparam logic [3:0] ADDR_REVAL = 4'hC;

    // ----------------------------------------------------------------
    // control field positions
    // ----------------------------------------------------------------
    localparam int CTRL_DISABLE0 = 0;
    localparam int CTRL_DISABLE1 = 1;
    localparam int CTRL_GPIO_LOSS = 2;
    localparam int CTRL_GPIO_IRQ = 3;
    localparam int CTRL_REFDIV_PD = 4;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [4:0] CONTROL_RESET = 5'h10;
    localparam logic [7:0] REVAL_RESET = 8'h04;
    localparam logic [1:0] MISSING_EDGE_LIMIT = 2'h3;
    localparam int REVAL_WIDTH = 8;
    localparam int INPUT_COUNT = 2;

    // ----------------------------------------------------------------
    // monitor state and carried status
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MON_VALID = 2'b00,
        MON_LOST = 2'b01,
        MON_CHECK = 2'b11
    } iclm_mon_state_type;

    typedef struct packed {
        logic momentary;
        logic lossEvent;
        logic validEvent;
    } iclm_mon_status_type;

endpackage : iclm_pkg

// File: design/iclm_input_monitor.sv
// per-input activity monitor: missing-edge loss and revalidation
`timescale 1ns/1ps
`default_nettype none
module iclm_input_monitor
    import iclm_pkg::*;
#(
    parameter int RevalWidth = REVAL_WIDTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // synchronised edge strobes
    input wire logic inputEdge,
    input wire logic refEdge,
    // configuration
    input wire logic enable,
    input wire logic [RevalWidth-1:0] revalidationCount,
    // result
    output iclm_mon_status_type status
);

    iclm_mon_state_type state_q;
    logic [1:0] missing_q;
    logic [RevalWidth-1:0] good_q;
    logic lossEvent_q;
    logic validEvent_q;

    // ----------------------------------------------------------------
    // missing-edge counter
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset || !enable) begin
            missing_q <= 2'h0;
        end else if (inputEdge) begin
            missing_q <= 2'h0; // [RULE_16]
        // no absolute timeout: the slowest input watched is set by the divider rate [RULE_12]
        end else if (refEdge && missing_q != MISSING_EDGE_LIMIT) begin
            missing_q <= missing_q + 2'h1; // [RULE_16]
        end
    end

    // ----------------------------------------------------------------
    // validity state
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        lossEvent_q <= 1'b0;
        validEvent_q <= 1'b0;
        if (reset || !enable) begin
            state_q <= MON_VALID;
            good_q <= '0;
        end else begin
            case (state_q)
                MON_VALID: begin
                    if (refEdge && !inputEdge && missing_q == MISSING_EDGE_LIMIT - 2'h1) begin
                        state_q <= MON_LOST; // [RULE_03]
                        lossEvent_q <= 1'b1;
                    end
                end
                MON_LOST: begin
                    if (inputEdge) begin
                        state_q <= MON_CHECK;
                        good_q <= {{(RevalWidth-1){1'b0}}, 1'b1};
                    end
                end
                MON_CHECK: begin
                    if (refEdge && !inputEdge && missing_q == MISSING_EDGE_LIMIT - 2'h1) begin
                        // a loss during revalidation is a fresh event for a cleared flag
                        state_q <= MON_LOST;
                        lossEvent_q <= 1'b1; // [RULE_15]
                    end else if (good_q >= revalidationCount) begin
                        state_q <= MON_VALID; // [RULE_13]
                        validEvent_q <= 1'b1;
                    end else if (inputEdge) begin
                        good_q <= good_q + {{(RevalWidth-1){1'b0}}, 1'b1}; // [RULE_13]
                    end
                end
                default: begin
                    state_q <= MON_VALID;
                end
            endcase
        end
    end

    assign status.momentary = (state_q != MON_VALID);
    assign status.lossEvent = lossEvent_q;
    assign status.validEvent = validEvent_q;

endmodule // iclm_input_monitor
`default_nettype wire

// File: design/iclm_loss_monitor.sv
// loss-of-signal monitor for two reference inputs, Wishbone slave
//
// Function
// (RULE_01) Each reference input is watched on its own at all times and a static input counts as inactive.
// (RULE_02) Each input after its pre-divider is compared against the loss reference divider output.
// (RULE_03) Three consecutive missing edges declare an input invalid and set its loss indication.
// (RULE_04) Each input has a momentary loss flag following the condition and a sticky flag held until cleared.
// (RULE_05) The routed loss output is 0 when any enabled input is lost and 1 when all enabled inputs run.
// (RULE_06) Loss may instead be shown on the output pin as an interrupt indication.
// (RULE_07) Disabled inputs are excluded from loss reporting so unused inputs raise no false loss.
// (RULE_08) Host programs the reference divider to match the pre-divided input frequency in dual and synth modes.
// (RULE_09) In oscillator mode the oscillator drives the source multiplexer and host matches the divider to it.
// (RULE_10) The monitor works in every PLL mode using the reference divider output as comparison.
// (RULE_11) Host keeps the pre-divided monitored frequency at or below 250MHz.
// (RULE_12) The slowest monitorable input is oscillator frequency over the largest divider, 0.24MHz.
// (RULE_13) An input is valid again after a configurable count of consecutive returned periods.
// (RULE_14) Host configures the reference divider and clears its power-down bit before relying on detection.
// (RULE_15) Clearing a sticky flag re-arms the input so a new loss event can be raised.
// (RULE_16) Reference edges since the last input edge are counted, restarted per input edge, flagging at threshold.
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iclm_loss_monitor
    import iclm_pkg::*;
#(
    parameter int RevalWidth = REVAL_WIDTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pre-divided reference inputs and loss reference divider output
    input wire logic [INPUT_COUNT-1:0] referenceInput,
    input wire logic lossReferenceDivider,
    // pin outputs
    output logic inputLossIndicator,
    output logic referenceDividerPowerdown
);

    // ----------------------------------------------------------------
    // input synchronisers and edge detect
    // ----------------------------------------------------------------
    // the divided clocks arrive asynchronously; the rate limit keeps them
    // well below half of core_clk so rising edges are not missed
    logic [INPUT_COUNT-1:0] inMeta_q;
    logic [INPUT_COUNT-1:0] inSync_q;
    logic [INPUT_COUNT-1:0] inPrev_q;
    logic refMeta_q;
    logic refSync_q;
    logic refPrev_q;

    // reference inputs: two stages, then a delayed copy for the edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            inMeta_q <= '0;
            inSync_q <= '0;
            inPrev_q <= '0;
        end else begin
            inMeta_q <= referenceInput;
            inSync_q <= inMeta_q;
            inPrev_q <= inSync_q;
        end
    end

    // loss reference divider output, same treatment
    always_ff @(posedge core_clk) begin
        if (reset) begin
            refMeta_q <= 1'b0;
            refSync_q <= 1'b0;
            refPrev_q <= 1'b0;
        end else begin
            refMeta_q <= lossReferenceDivider;
            refSync_q <= refMeta_q;
            refPrev_q <= refSync_q;
        end
    end

    logic [INPUT_COUNT-1:0] inEdge;
    logic refEdge;
    assign inEdge = inSync_q & ~inPrev_q; // [RULE_02]
    assign refEdge = refSync_q & ~refPrev_q; // [RULE_02] [RULE_09] [RULE_10]

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [4:0] control_q;
    logic [RevalWidth-1:0] reval_q;
    logic busAccess;
    logic busRead;
    logic busCommit;
    logic controlWrite;
    logic revalWrite;
    logic stickyWrite;

    // a request is taken while ack is low, so every access is answered once
    assign busAccess = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busRead = busAccess && !wb_we_i;
    // writes land at the edge where the master sees ack, never earlier
    assign busCommit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    function automatic logic writeHit(input logic commit, input logic sel0,
                                      input logic [3:0] adr, input logic [3:0] target);
        writeHit = commit && sel0 && (adr == target);
    endfunction

    assign controlWrite = writeHit(busCommit, wb_sel_i[0], wb_adr_i, ADDR_CONTROL);
    assign revalWrite = writeHit(busCommit, wb_sel_i[0], wb_adr_i, ADDR_REVAL);
    assign stickyWrite = writeHit(busCommit, wb_sel_i[0], wb_adr_i, ADDR_STICKY);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            control_q <= CONTROL_RESET;
        end else if (controlWrite) begin
            control_q <= wb_dat_i[4:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            reval_q <= RevalWidth'(REVAL_RESET);
        end else if (revalWrite) begin
            reval_q <= wb_dat_i[RevalWidth-1:0];
        end
    end

    logic [INPUT_COUNT-1:0] inputDisable;
    assign inputDisable = {control_q[CTRL_DISABLE1], control_q[CTRL_DISABLE0]};

    // ----------------------------------------------------------------
    // per-input monitors
    // ----------------------------------------------------------------
    iclm_mon_status_type monStatus [INPUT_COUNT];
    logic [INPUT_COUNT-1:0] momentary;
    logic [INPUT_COUNT-1:0] lossEvent;

    // powered-down divider gives no comparison edges, so monitors hold off
    logic monitorsOn;
    assign monitorsOn = !control_q[CTRL_REFDIV_PD]; // [RULE_14]

    for (genvar i = 0; i < INPUT_COUNT; i++) begin : g_mon
        iclm_input_monitor #(
            .RevalWidth(RevalWidth)
        ) u_mon (
            .core_clk(core_clk),
            .reset(reset),
            .inputEdge(inEdge[i]),
            .refEdge(refEdge),
            .enable(monitorsOn && !inputDisable[i]), // [RULE_01] [RULE_07]
            .revalidationCount(reval_q),
            .status(monStatus[i])
        );
        assign momentary[i] = monStatus[i].momentary; // [RULE_04]
        assign lossEvent[i] = monStatus[i].lossEvent;
    end

    // ----------------------------------------------------------------
    // sticky flags with re-arm
    // ----------------------------------------------------------------
    logic [INPUT_COUNT-1:0] sticky_q;
    logic [INPUT_COUNT-1:0] stickyClear;
    assign stickyClear = stickyWrite ? wb_dat_i[INPUT_COUNT-1:0] : '0;

    // set wins over a clear in the same cycle; a cleared flag sets again
    // on the next loss event only
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sticky_q <= '0;
        end else begin
            sticky_q <= (sticky_q & ~stickyClear) | lossEvent; // [RULE_04] [RULE_15]
        end
    end

    // ----------------------------------------------------------------
    // output pins
    // ----------------------------------------------------------------
    logic anyLoss, anySticky;
    assign anyLoss = |(momentary & ~inputDisable); // [RULE_07]
    assign anySticky = |(sticky_q & ~inputDisable);

    function automatic logic gpioLevel(input logic [4:0] ctrl, input logic lost,
                                       input logic pending);
        if (ctrl[CTRL_GPIO_IRQ]) begin
            gpioLevel = pending; // [RULE_06]
        end else if (ctrl[CTRL_GPIO_LOSS]) begin
            gpioLevel = !lost; // [RULE_05]
        end else begin
            gpioLevel = 1'b1;
        end
    endfunction

    always_ff @(posedge core_clk) begin
        if (reset) begin
            referenceDividerPowerdown <= 1'b1;
        end else begin
            referenceDividerPowerdown <= control_q[CTRL_REFDIV_PD]; // [RULE_14]
        end
    end

    // interrupt view takes priority over the loss level view
    always_ff @(posedge core_clk) begin
        if (reset) begin
            inputLossIndicator <= 1'b1;
        end else begin
            inputLossIndicator <= gpioLevel(control_q, anyLoss, anySticky);
        end
    end

    // ----------------------------------------------------------------
    // bus read and ack
    // ----------------------------------------------------------------
    function automatic logic [31:0] readMux(input logic [3:0] adr);
        case (adr)
            ADDR_CONTROL: readMux = {27'h0, control_q};
            ADDR_STATUS: readMux = {30'h0, momentary};
            ADDR_STICKY: readMux = {30'h0, sticky_q};
            ADDR_REVAL: readMux = {{(32-RevalWidth){1'b0}}, reval_q};
            default: readMux = 32'h0;
        endcase
    endfunction

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busAccess;
        end
    end

    // data stands with ack only, zero otherwise
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wb_dat_o <= 32'h0;
        end else begin
            wb_dat_o <= busRead ? readMux(wb_adr_i) : 32'h0;
        end
    end

endmodule // iclm_loss_monitor
`default_nettype wire

// File: verification/iclm_loss_monitor_props.sv
// port checker for the input clock loss monitor
`timescale 1ns/1ps
`default_nettype none
module iclm_loss_monitor_props
    import iclm_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // clocks and pins
    input wire logic [INPUT_COUNT-1:0] referenceInput,
    input wire logic lossReferenceDivider,
    input wire logic inputLossIndicator,
    input wire logic referenceDividerPowerdown
);
    logic refPrev_q;
    logic [1:0] inPrev_q;
    logic [2:0] miss_q [2];
    logic [4:0] sinceWr_q;
    logic [5:0] ctrlAge_q;
    logic [4:0] ctrl_q;
    logic wrDone;
    logic ctrlWr;
    logic levelLost;
    assign wrDone = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign ctrlWr = wrDone & wb_sel_i[0] & (wb_adr_i == ADDR_CONTROL);
    // raw pins run ahead of the design's synchroniser, so 5 misses is safely lost
    assign levelLost = ctrl_q[2] & ~ctrl_q[3] & ~ctrl_q[4]
        & (((miss_q[0] > 3'h4) & ~ctrl_q[0]) | ((miss_q[1] > 3'h4) & ~ctrl_q[1]));
    always_ff @(posedge core_clk) begin
        refPrev_q <= lossReferenceDivider;
        inPrev_q <= referenceInput;
        for (int i = 0; i < 2; i++) begin
            if (reset || (referenceInput[i] && !inPrev_q[i])) begin
                miss_q[i] <= 3'h0;
            end else if (lossReferenceDivider && !refPrev_q && miss_q[i] != 3'h7) begin
                miss_q[i] <= miss_q[i] + 3'h1;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sinceWr_q <= 5'h1F;
            ctrlAge_q <= 6'h3F;
            ctrl_q <= CONTROL_RESET;
        end else begin
            sinceWr_q <= wrDone ? 5'h00 : sinceWr_q + {4'h0, sinceWr_q != 5'h1F};
            ctrlAge_q <= ctrlWr ? 6'h00 : ctrlAge_q + {5'h00, ctrlAge_q != 6'h3F};
            if (ctrlWr) begin
                ctrl_q <= wb_dat_i[4:0];
            end
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_zero;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_zero: assert property (p_dat_zero) else $error("data without ack");
    property p_reset_out;
        $fell(reset) |-> referenceDividerPowerdown && inputLossIndicator && !wb_ack_o;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("bad reset outputs");
    property p_pd_follow;
        ctrlAge_q == 6'h02 |-> referenceDividerPowerdown == ctrl_q[4];
    endproperty
    a_pd_follow: assert property (p_pd_follow) else $error("powerdown wrong");
    property p_pd_hold;
        $changed(referenceDividerPowerdown) && !$past(reset) |-> ctrlAge_q <= 6'h03;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("powerdown moved");
    property p_ind_fall;
        $fell(inputLossIndicator) && !$past(reset)
            |-> sinceWr_q <= 5'h03 || miss_q[0] > 3'h2 || miss_q[1] > 3'h2;
    endproperty
    a_ind_fall: assert property (p_ind_fall) else $error("early loss");
    property p_loss_level;
        levelLost && ctrlAge_q == 6'h3F |-> !inputLossIndicator;
    endproperty
    a_loss_level: assert property (p_loss_level) else $error("loss unseen");
endmodule // iclm_loss_monitor_props
bind iclm_loss_monitor iclm_loss_monitor_props i_props (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .referenceInput(referenceInput),
    .lossReferenceDivider(lossReferenceDivider), .inputLossIndicator(inputLossIndicator),
    .referenceDividerPowerdown(referenceDividerPowerdown)
);
`default_nettype wire

// File: verification/iclm_clock_source_model.sv
// behavioural reference clock sources feeding the loss monitor
`timescale 1ns/1ps
`default_nettype none
module iclm_clock_source_model #(
    parameter realtime HalfPeriod = 32.0
) (
    // source control
    input wire logic [1:0] runSrc,
    // clock outputs
    output logic [1:0] referenceInput,
    output logic lossReferenceDivider
);
    // divider rate matches the inputs, far under the monitor's ceiling
    initial begin
        lossReferenceDivider = 1'b0;
        forever #(HalfPeriod) lossReferenceDivider = ~lossReferenceDivider;
    end
    // a stopped input freezes at its level: the static case
    initial begin
        referenceInput = 2'b00;
        #(HalfPeriod / 4);
        forever #(HalfPeriod) referenceInput = referenceInput ^ runSrc;
    end
endmodule // iclm_clock_source_model
`default_nettype wire

// File: verification/test_input_clock_loss_monitor.sv
// self-checking bench for the input clock loss monitor
`timescale 1ns/1ps
`default_nettype none
module test_input_clock_loss_monitor
    import iclm_pkg::*;
;
    logic core_clk, reset, wbCyc, wbStb, wbWe, wbAck, lossInd, refPd, refDiv;
    logic [3:0] wbAdr, wbSel;
    logic [31:0] wbDatI, wbDatO, rdData;
    logic [1:0] refIn, runSrc, lostNow, stickyNow;
    logic [4:0] ctrl;
    logic [7:0] reval;
    int errors, n_tests, cycles, seed;
    iclm_loss_monitor i_dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .referenceInput(refIn),
        .lossReferenceDivider(refDiv), .inputLossIndicator(lossInd),
        .referenceDividerPowerdown(refPd));
    iclm_clock_source_model i_src (.runSrc(runSrc), .referenceInput(refIn),
        .lossReferenceDivider(refDiv));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end
    function automatic logic gpioExp(logic [4:0] c, logic [1:0] lst, logic [1:0] stk);
        if (c[3]) return |(stk & ~c[1:0]);
        if (c[2]) return ~|(lst & ~c[1:0]);
        return 1'b1;
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(logic we, logic [3:0] a, logic [31:0] d, logic [3:0] s);
        @(posedge core_clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} <= {2'b11, we, a, d, s};
        @(posedge core_clk);
        while (wbAck !== 1'b1) @(posedge core_clk);
        rdData = wbDatO;
        {wbCyc, wbStb, wbWe} <= 3'h0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e, string nm);
        xfer(1'b0, a, 32'h0, 4'hF);
        chk(nm, e, rdData);
    endtask
    task automatic setCtrl(logic [4:0] c);
        ctrl = c;
        xfer(1'b1, ADDR_CONTROL, {24'($random(seed)), 3'h0, c}, 4'hF);
    endtask
    task automatic pin(string nm);
        chk(nm, {31'h0, gpioExp(ctrl, lostNow, stickyNow)}, {31'h0, lossInd});
    endtask
    initial begin
        {seed, errors, n_tests, cycles} = {32'h68A8, 96'h0};
        {reset, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = {4'h8, 8'h0F, 32'h0};
        {runSrc, lostNow, stickyNow, ctrl} = {6'h30, CONTROL_RESET};
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        rd(ADDR_CONTROL, 32'h10, "control");
        chk("powerdown", 32'h1, {31'h0, refPd});
        rd(ADDR_STICKY, 32'h0, "sticky");
        xfer(1'b1, 4'h3, $random(seed), 4'hF);
        rd(4'h3, 32'h0, "unmapped");
        rd(ADDR_REVAL, 32'h4, "reval");
        reval = 8'(($random(seed) & 7) + 1);
        xfer(1'b1, ADDR_REVAL, {24'h0, reval}, 4'hF);
        xfer(1'b1, ADDR_REVAL, 32'h0, 4'hE);
        rd(ADDR_REVAL, {24'h0, reval}, "reval");
        pin("gpio idle");
        setCtrl(5'h04);
        repeat (80) @(posedge core_clk);
        chk("powerdown", 32'h0, {31'h0, refPd});
        rd(ADDR_STATUS, 32'h0, "status");
        pin("gpio running");
        $display("test setup done");
        runSrc <= 2'b10;
        {lostNow, stickyNow} = 4'h5;
        repeat (60) @(posedge core_clk);
        rd(ADDR_STATUS, 32'h1, "status");
        rd(ADDR_STICKY, 32'h1, "sticky");
        for (int i = 0; i < 3; i++) begin
            setCtrl(5'(4 * i));
            repeat (4) @(posedge core_clk);
            pin("gpio mode");
        end
        $display("test loss done");
        runSrc <= 2'b11;
        lostNow = 2'b00;
        repeat (8 * int'(reval) + 40) @(posedge core_clk);
        rd(ADDR_STATUS, 32'h0, "status");
        rd(ADDR_STICKY, 32'h1, "sticky");
        pin("gpio irq held");
        xfer(1'b1, ADDR_STICKY, 32'h1, 4'hF);
        stickyNow = 2'b00;
        rd(ADDR_STICKY, 32'h0, "sticky clear");
        pin("gpio irq clear");
        runSrc <= 2'b10;
        {lostNow, stickyNow} = 4'h5;
        repeat (60) @(posedge core_clk);
        rd(ADDR_STICKY, 32'h1, "sticky rearm");
        pin("gpio irq again");
        $display("test revalidate done");
        setCtrl(5'h05);
        repeat (8) @(posedge core_clk);
        rd(ADDR_STATUS, 32'h0, "status disabled");
        pin("gpio disabled");
        $display("test disable done");
        summarize();
    end
endmodule // test_input_clock_loss_monitor
`default_nettype wire
